//--- verilog/hle_params.svh
`ifndef HLE_PARAMS_SVH
`define HLE_PARAMS_SVH
`define HLE_AW            8
`define HLE_CTRL_OFS      8'h00
`define HLE_CMD_OFS       8'h04
`define HLE_MAIN_STAT_OFS 8'h20
`define HLE_EXT_STAT_OFS  8'h24
`define HLE_MAIN_CLR_OFS  8'h28
`define HLE_EXT_CLR_OFS   8'h2c
`define HLE_MAIN_EN_OFS   8'h30
`define HLE_EXT_EN_OFS    8'h34
`define HLE_CTRL_AUTO     0
`define HLE_CMD_ACK       7
`define HLE_CMD_TRANSP    3
`define HLE_CMD_IFRAME    2
`define HLE_CMD_CLOSE     1
`define HLE_MS_MSG_END    7
`define HLE_MS_POOL_FULL  6
`define HLE_MS_STAT_CHG   5
`define HLE_MS_TX_READY   4
`define HLE_MS_TIMER      3
`define HLE_XS_REPEAT     7
`define HLE_XS_UNDERRUN   6
`define HLE_XS_PROTO      5
`define HLE_XS_OVERFLOW   4
`define HLE_RESP_OKAY     2'b00
`define HLE_RESP_SLVERR   2'b10
`endif

//--- verilog/hle_pkg.sv
package hle_pkg;
    typedef enum logic [2:0] {
        TX_IDLE     = 3'b001,
        TX_ACTIVE   = 3'b010,
        TX_WAIT_ACK = 3'b100
    } hle_tx_e;
    typedef logic [7:0] hle_byte_t;
endpackage : hle_pkg

//--- verilog/hle_reg_if.sv
`timescale 1ns/100ps
interface hle_reg_if;
    logic                wrEn;
    logic [7:0]          wrAddr;
    logic [31:0]         wrData;
    logic [3:0]          wrStrb;
    logic                wrHit;
    logic                rdEn;
    logic [7:0]          rdAddr;
    logic [31:0]         rdData;
    logic                rdHit;
    modport bus  (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                  input  wrHit, rdData, rdHit);
    modport regs (input  wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                  output wrHit, rdData, rdHit);
endinterface : hle_reg_if

//--- verilog/hle_axil_slave.sv
`timescale 1ns/100ps
`include "hle_params.svh"
module hle_axil_slave (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    hle_reg_if.bus           rif
);
    logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
    logic [7:0]  awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rData_q, rData_d;
    logic [3:0]  wStrb_q, wStrb_d;
    logic        bValid_q, bValid_d, rValid_q, rValid_d;
    logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
    logic        awGot, wGot;

    assign awready = !awHeld_q && !bValid_q;
    assign wready  = !wHeld_q && !bValid_q;
    assign arready = !rValid_q;
    assign bvalid  = bValid_q;
    assign bresp   = bResp_q;
    assign rvalid  = rValid_q;
    assign rdata   = rData_q;
    assign rresp   = rResp_q;

    always_comb begin
        awGot      = awHeld_q || (awvalid && awready);
        wGot       = wHeld_q || (wvalid && wready);
        awAddr_d   = awHeld_q ? awAddr_q : awaddr;
        wData_d    = wHeld_q ? wData_q : wdata;
        wStrb_d    = wHeld_q ? wStrb_q : wstrb;
        rif.wrEn   = awGot && wGot && !bValid_q;
        rif.wrAddr = awAddr_d;
        rif.wrData = wData_d;
        rif.wrStrb = wStrb_d;
        awHeld_d   = awGot && !rif.wrEn;
        wHeld_d    = wGot && !rif.wrEn;
        bValid_d   = rif.wrEn || (bValid_q && !bready);
        bResp_d    = bResp_q;
        if (rif.wrEn) begin
            bResp_d = rif.wrHit ? `HLE_RESP_OKAY : `HLE_RESP_SLVERR;
        end
        rif.rdEn   = arvalid && arready;
        rif.rdAddr = araddr;
        rValid_d   = rif.rdEn || (rValid_q && !rready);
        rData_d    = rData_q;
        rResp_d    = rResp_q;
        if (rif.rdEn) begin
            rData_d = rif.rdHit ? rif.rdData : 32'h0000_0000;
            rResp_d = rif.rdHit ? `HLE_RESP_OKAY : `HLE_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q  <= 2'h0;
            rValid_q <= 1'b0;
            rData_q  <= 32'h0000_0000;
            rResp_q  <= 2'h0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q  <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q  <= wData_d;
            wStrb_q  <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q  <= bResp_d;
            rValid_q <= rValid_d;
            rData_q  <= rData_d;
            rResp_q  <= rResp_d;
        end
    end
endmodule : hle_axil_slave

//--- verilog/hle_status_reg.sv
`timescale 1ns/100ps
module hle_status_reg (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] setBits,
    input  wire logic       clrWr,
    input  wire logic [7:0] clrBits,
    input  wire logic       enWr,
    input  wire logic [7:0] enBits,
    output logic [7:0]      status,
    output logic [7:0]      enable,
    output logic            irq
);
    logic [7:0] stat_q, stat_d, en_q, en_d;

    always_comb begin
        // Set wins over a clear in the same cycle
        stat_d = (stat_q & ~(clrWr ? clrBits : 8'h00)) | setBits;
        en_d   = enWr ? enBits : en_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= 8'h00;
            en_q   <= 8'h00;
        end else begin
            stat_q <= stat_d;
            en_q   <= en_d;
        end
    end

    assign status = stat_q;
    assign enable = en_q;
    assign irq    = |(stat_q & en_q);
endmodule : hle_status_reg

//--- verilog/hle_event_ctrl.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "hle_params.svh"
module hle_event_ctrl (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        rxBlockReady,
    input  wire logic        rxFrameEnd,
    input  wire logic        rxFrameDiscard,
    input  wire logic        rxBadNr,
    input  wire logic        rxSWithIField,
    input  wire logic        rxINotCommand,
    input  wire logic        rxSUndefCtrl,
    input  wire logic        rxPeerStatusChg,
    input  wire logic        txPoolFree,
    input  wire logic        txFifoEmpty,
    input  wire logic        txFrameDone,
    input  wire logic        txError,
    input  wire logic        peerNak,
    input  wire logic        peerSAck,
    input  wire logic        extTimerExpired,
    input  wire logic        t200Expired,
    input  wire logic        n200Expired,
    output logic             rxAckPulse,
    output logic             txStartPulse,
    output logic             txAbortPulse,
    output logic             autoMode,
    output logic             irq
);
    hle_reg_if rif ();

    hle_axil_slave u_bus (
        .clk     (clk),
        .rstn    (rstn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif)
    );

    function automatic logic wrAt(input logic [7:0] ofs);
        wrAt = rif.wrEn && rif.wrStrb[0] && (rif.wrAddr == ofs);
    endfunction : wrAt

    logic [7:0]      mainSet, extSet, mainStat, extStat, mainEn, extEn;
    logic            mainIrq, extIrq, mainClrWr, extClrWr, mainEnWr, extEnWr;
    hle_pkg::hle_tx_e txState_q, txState_d;
    logic            auto_q, auto_d;
    logic            close_q, close_d;
    logic            poolFree_q;
    logic            rxHold_q, rxHold_d;
    logic            pendPf_q, pendPf_d, pendMe_q, pendMe_d;
    logic            ack_q, ack_d, start_q, start_d, abort_q, abort_d;
    logic            cmdWr, ackCmd, txCmd, underrun, poolRise;
    logic            wantPf, wantMe, canReport, rpfSet, rmeSet;
    hle_pkg::hle_byte_t cmdByte;

    hle_status_reg u_main (
        .clk     (clk),
        .rstn    (rstn),
        .setBits (mainSet),
        .clrWr   (mainClrWr),
        .clrBits (rif.wrData[7:0]),
        .enWr    (mainEnWr),
        .enBits  (rif.wrData[7:0]),
        .status  (mainStat),
        .enable  (mainEn),
        .irq     (mainIrq)
    );

    hle_status_reg u_ext (
        .clk     (clk),
        .rstn    (rstn),
        .setBits (extSet),
        .clrWr   (extClrWr),
        .clrBits (rif.wrData[7:0]),
        .enWr    (extEnWr),
        .enBits  (rif.wrData[7:0]),
        .status  (extStat),
        .enable  (extEn),
        .irq     (extIrq)
    );

    always_comb begin
        rif.wrHit = 1'b0;
        case (rif.wrAddr)
            `HLE_CTRL_OFS, `HLE_CMD_OFS, `HLE_MAIN_CLR_OFS, `HLE_EXT_CLR_OFS,
            `HLE_MAIN_EN_OFS, `HLE_EXT_EN_OFS: rif.wrHit = 1'b1;
            default: rif.wrHit = 1'b0;
        endcase
        rif.rdHit  = 1'b1;
        rif.rdData = 32'h0000_0000;
        case (rif.rdAddr)
            `HLE_CTRL_OFS:      rif.rdData = {31'h0000_0000, auto_q};
            `HLE_MAIN_STAT_OFS: rif.rdData = {24'h00_0000, mainStat};
            `HLE_EXT_STAT_OFS:  rif.rdData = {24'h00_0000, extStat};
            `HLE_MAIN_EN_OFS:   rif.rdData = {24'h00_0000, mainEn};
            `HLE_EXT_EN_OFS:    rif.rdData = {24'h00_0000, extEn};
            // Command and clear registers are write-only and read zero
            `HLE_CMD_OFS, `HLE_MAIN_CLR_OFS, `HLE_EXT_CLR_OFS: rif.rdData = 32'h0000_0000;
            default:            rif.rdHit = 1'b0;
        endcase
    end

    always_comb begin
        cmdWr   = wrAt(`HLE_CMD_OFS);
        mainClrWr = wrAt(`HLE_MAIN_CLR_OFS);
        extClrWr  = wrAt(`HLE_EXT_CLR_OFS);
        mainEnWr  = wrAt(`HLE_MAIN_EN_OFS);
        extEnWr   = wrAt(`HLE_EXT_EN_OFS);
        cmdByte = rif.wrData[7:0];
        ackCmd  = cmdWr && cmdByte[`HLE_CMD_ACK];
        txCmd   = cmdWr && (cmdByte[`HLE_CMD_IFRAME] || cmdByte[`HLE_CMD_TRANSP]);
        auto_d  = wrAt(`HLE_CTRL_OFS) ? rif.wrData[`HLE_CTRL_AUTO] : auto_q;

        // A second pool may fill before the host acknowledges the first:
        // its report is held back until the acknowledge command.
        canReport = !rxHold_q || ackCmd;
        wantPf    = rxBlockReady || pendPf_q;
        wantMe    = rxFrameEnd || pendMe_q;
        rpfSet    = canReport && wantPf;
        rmeSet    = canReport && !wantPf && wantMe;
        pendPf_d  = wantPf && !rpfSet;
        pendMe_d  = wantMe && !rmeSet;
        rxHold_d  = rpfSet || rmeSet || (rxHold_q && !ackCmd);
        ack_d     = ackCmd;

        poolRise  = txPoolFree && !poolFree_q;
        underrun  = (txState_q == hle_pkg::TX_ACTIVE) && txFifoEmpty && !close_q;
        txState_d = txState_q;
        close_d   = close_q;
        start_d   = txCmd;
        abort_d   = 1'b0;
        case (txState_q)
            hle_pkg::TX_IDLE: begin
                if (txCmd) begin
                    txState_d = hle_pkg::TX_ACTIVE;
                    close_d   = cmdByte[`HLE_CMD_CLOSE];
                end
            end
            hle_pkg::TX_ACTIVE: begin
                if (txCmd) begin
                    close_d = cmdByte[`HLE_CMD_CLOSE];
                end else if (underrun) begin
                    abort_d   = 1'b1;
                    txState_d = hle_pkg::TX_IDLE;
                    close_d   = 1'b0;
                end else if (txFrameDone) begin
                    // Closed I frame in auto mode waits for the peer's S frame
                    txState_d = (auto_q && close_q) ? hle_pkg::TX_WAIT_ACK
                                                    : hle_pkg::TX_IDLE;
                    close_d   = 1'b0;
                end
            end
            hle_pkg::TX_WAIT_ACK: begin
                if (peerSAck) begin
                    txState_d = hle_pkg::TX_IDLE;
                end
            end
            default: begin
                txState_d = hle_pkg::TX_IDLE;
                close_d   = 1'b0;
            end
        endcase

        mainSet = 8'h00;
        mainSet[`HLE_MS_POOL_FULL] = rpfSet;
        mainSet[`HLE_MS_MSG_END]   = rmeSet;
        mainSet[`HLE_MS_TX_READY]  =
            (poolRise && txState_q != hle_pkg::TX_WAIT_ACK)
            || (txState_q == hle_pkg::TX_WAIT_ACK && peerSAck);
        mainSet[`HLE_MS_STAT_CHG]  = auto_q && rxPeerStatusChg;
        mainSet[`HLE_MS_TIMER]     = extTimerExpired
            || (auto_q && t200Expired && n200Expired);
        extSet = 8'h00;
        extSet[`HLE_XS_OVERFLOW] = rxFrameDiscard;
        extSet[`HLE_XS_PROTO]    = rxBadNr || rxINotCommand || rxSUndefCtrl
            || (auto_q && rxSWithIField);
        extSet[`HLE_XS_REPEAT]   = txError || (auto_q && peerNak);
        extSet[`HLE_XS_UNDERRUN] = underrun;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txState_q  <= hle_pkg::TX_IDLE;
            auto_q     <= 1'b0;
            close_q    <= 1'b0;
            poolFree_q <= 1'b0;
            rxHold_q   <= 1'b0;
            pendPf_q   <= 1'b0;
            pendMe_q   <= 1'b0;
            ack_q      <= 1'b0;
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
        end else begin
            txState_q  <= txState_d;
            auto_q     <= auto_d;
            close_q    <= close_d;
            poolFree_q <= txPoolFree;
            rxHold_q   <= rxHold_d;
            pendPf_q   <= pendPf_d;
            pendMe_q   <= pendMe_d;
            ack_q      <= ack_d;
            start_q    <= start_d;
            abort_q    <= abort_d;
        end
    end

    assign rxAckPulse   = ack_q;
    assign txStartPulse = start_q;
    assign txAbortPulse = abort_q;
    assign autoMode     = auto_q;
    assign irq          = mainIrq || extIrq;
    property p_pool_full;
        @(posedge clk) disable iff (!rstn)
        rxBlockReady && !rxHold_q |=> mainStat[`HLE_MS_POOL_FULL] && rxHold_q;
    endproperty
    a_pool_full: assert property (p_pool_full)
        else $error("pool-full not raised");
    property p_msg_end;
        @(posedge clk) disable iff (!rstn)
        rxFrameEnd && !rxBlockReady && !rxHold_q && !pendPf_q
            |=> mainStat[`HLE_MS_MSG_END];
    endproperty
    a_msg_end: assert property (p_msg_end)
        else $error("message-end not raised");
    property p_overflow;
        @(posedge clk) disable iff (!rstn)
        rxFrameDiscard |=> extStat[`HLE_XS_OVERFLOW];
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not raised");
    property p_proto;
        @(posedge clk) disable iff (!rstn)
        rxSWithIField && !auto_q && !rxBadNr && !rxINotCommand && !rxSUndefCtrl
            && !extStat[`HLE_XS_PROTO] |=> !extStat[`HLE_XS_PROTO];
    endproperty
    a_proto: assert property (p_proto)
        else $error("protocol error raised outside auto mode");
    property p_tx_ready;
        @(posedge clk) disable iff (!rstn)
        $rose(txPoolFree) && txState_q == hle_pkg::TX_IDLE
            |-> ##1 mainStat[`HLE_MS_TX_READY];
    endproperty
    a_tx_ready: assert property (p_tx_ready)
        else $error("pool-ready not raised");
    property p_wait_ack;
        @(posedge clk) disable iff (!rstn)
        txState_q == hle_pkg::TX_WAIT_ACK && !peerSAck && !mainStat[`HLE_MS_TX_READY]
            |=> !mainStat[`HLE_MS_TX_READY];
    endproperty
    a_wait_ack: assert property (p_wait_ack)
        else $error("pool-ready before peer ack");
    property p_repeat;
        @(posedge clk) disable iff (!rstn)
        auto_q && peerNak |=> extStat[`HLE_XS_REPEAT];
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat not raised");
    property p_underrun;
        @(posedge clk) disable iff (!rstn)
        underrun |=> txAbortPulse && extStat[`HLE_XS_UNDERRUN]
            && txState_q == hle_pkg::TX_IDLE;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun not handled");
    property p_stat_chg;
        @(posedge clk) disable iff (!rstn)
        !auto_q && !mainStat[`HLE_MS_STAT_CHG] |=> !mainStat[`HLE_MS_STAT_CHG];
    endproperty
    a_stat_chg: assert property (p_stat_chg)
        else $error("status change outside auto mode");
    property p_timer;
        @(posedge clk) disable iff (!rstn)
        auto_q && t200Expired && n200Expired |=> mainStat[`HLE_MS_TIMER];
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer event not raised");
    property p_sticky;
        @(posedge clk) disable iff (!rstn)
        (mainStat[`HLE_MS_TIMER] && mainEn[`HLE_MS_TIMER])
            && !(mainClrWr && rif.wrData[`HLE_MS_TIMER])
            |=> mainStat[`HLE_MS_TIMER] && irq;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag or interrupt dropped");
endmodule : hle_event_ctrl

//--- tb/hle_host_model.sv
`timescale 1ns/100ps
module hle_host_model (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
    end
    // Ready is judged at the falling edge so the rising edge never races it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge clk);
            ta = awready & awvalid;
            tw = wready & wvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while ((awvalid & !ta) | (wvalid & !tw));
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd
    task automatic ack();
        logic [1:0] r;
        wr(8'h04, 32'h80, r);
    endtask : ack
    task automatic txCmd(input logic [7:0] c);
        logic [1:0] r;
        wr(8'h04, {24'h0, c}, r);
    endtask : txCmd
endmodule : hle_host_model

//--- tb/hle_event_ctrl_bench.sv
`timescale 1ns/100ps
module hle_event_ctrl_bench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [14:0] ev = '0;
    logic        txPoolFree = 1'b0;
    logic        txFifoEmpty = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        rxAckPulse, txStartPulse, txAbortPulse, autoMode, irq;
    int          fail_count = 0, checked = 0, nAck = 0, nStart = 0, nAbort = 0;

    always #50 clk = ~clk;
    always @(posedge clk) begin
        nAck <= nAck + rxAckPulse;
        nStart <= nStart + txStartPulse;
        nAbort <= nAbort + txAbortPulse;
    end

    hle_host_model i_host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    hle_event_ctrl i_dut (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .rxBlockReady(ev[0]), .rxFrameEnd(ev[1]),
        .rxFrameDiscard(ev[2]), .rxBadNr(ev[3]), .rxSWithIField(ev[4]),
        .rxINotCommand(ev[5]), .rxSUndefCtrl(ev[6]), .rxPeerStatusChg(ev[7]),
        .txPoolFree, .txFifoEmpty, .txFrameDone(ev[8]), .txError(ev[9]),
        .peerNak(ev[10]), .peerSAck(ev[11]), .extTimerExpired(ev[12]),
        .t200Expired(ev[13]), .n200Expired(ev[14]), .rxAckPulse, .txStartPulse,
        .txAbortPulse, .autoMode, .irq);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        i_host.wr(a, d, r);
    endtask : w
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        i_host.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, 32'h0);
    endtask : rc
    task automatic pulse(input logic [14:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
    endtask : pulse

    task automatic bus_edges();
        logic [31:0] d;
        logic [1:0]  r;
        rc(8'h20, 32'h0);
        rc(8'h24, 32'h0);
        i_host.rd(8'h40, d, r);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        i_host.wr(8'h20, 32'hff, r);
        chk({30'h0, r}, 32'h2);
        rc(8'h20, 32'h0);
        pulse(15'h1000);
        rc(8'h20, 32'h08);
        chk({31'h0, irq}, 32'h0);
        i_host.wr(8'h28, 32'hff, r);
        chk({30'h0, r}, 32'h0);
    endtask : bus_edges
    task automatic rx_flow();
        w(8'h30, 32'hf8);
        rc(8'h30, 32'hf8);
        pulse(15'h0001);
        rc(8'h20, 32'h40);
        chk({31'h0, irq}, 32'h1);
        // A frame end while a block is unacknowledged must wait for the ack
        pulse(15'h0002);
        rc(8'h20, 32'h40);
        w(8'h28, 32'h40);
        chk({31'h0, irq}, 32'h0);
        i_host.ack();
        rc(8'h20, 32'h80);
        chk(nAck, 32'h1);
        w(8'h28, 32'h80);
        i_host.ack();
        rc(8'h20, 32'h0);
        // Nothing held now, so a lone frame end is reported at once
        pulse(15'h0002);
        rc(8'h20, 32'h80);
        i_host.ack();
        w(8'h28, 32'h80);
    endtask : rx_flow
    task automatic ext_events();
        w(8'h34, 32'hf0);
        pulse(15'h0004);
        rc(8'h24, 32'h10);
        w(8'h2c, 32'hff);
        for (int i = 3; i < 7; i++) begin
            if (i != 4) begin
                pulse(15'h1 << i);
                rc(8'h24, 32'h20);
                w(8'h2c, 32'hff);
            end
        end
        pulse(15'h0200);
        rc(8'h24, 32'h80);
        chk({31'h0, irq}, 32'h1);
        w(8'h2c, 32'hff);
        i_host.txCmd(8'h0a);
        pulse(15'h0100);
        pulse(15'h6490);
        rc(8'h20, 32'h0);
        rc(8'h24, 32'h0);
    endtask : ext_events
    task automatic tx_flow();
        @(posedge clk) txPoolFree <= 1'b1;
        rc(8'h20, 32'h10);
        w(8'h28, 32'hff);
        i_host.txCmd(8'h04);
        @(posedge clk) txFifoEmpty <= 1'b1;
        rc(8'h24, 32'h40);
        chk(nAbort, 32'h1);
        chk(nStart, 32'h2);
        @(posedge clk) {txFifoEmpty, txPoolFree} <= 2'h0;
        w(8'h2c, 32'hff);
        i_host.txCmd(8'h0a);
        pulse(15'h0100);
        chk(nStart, 32'h3);
    endtask : tx_flow
    task automatic auto_flow();
        w(8'h00, 32'h1);
        rc(8'h00, 32'h1);
        chk({31'h0, autoMode}, 32'h1);
        i_host.txCmd(8'h06);
        pulse(15'h0100);
        @(posedge clk) txPoolFree <= 1'b1;
        rc(8'h20, 32'h0);
        pulse(15'h0800);
        rc(8'h20, 32'h10);
        w(8'h28, 32'hff);
        pulse(15'h6080);
        rc(8'h20, 32'h28);
        pulse(15'h0410);
        rc(8'h24, 32'ha0);
        chk(nStart, 32'h4);
    endtask : auto_flow

    task automatic results();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus_edges();
        rx_flow();
        ext_events();
        tx_flow();
        auto_flow();
        results();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule : hle_event_ctrl_bench
